//--- shared/rsc_pkg.sv
// constants for the reset sequencer and main clock path
// assumes a 20 MHz pclk and a 32-bit apb register bus
`default_nettype none
package rsc_pkg;
    // ************************************
    // register map
    // ************************************
    localparam logic [7:0]  OFF_OPT   = 8'h00;
    localparam logic [7:0]  OFF_STAT  = 8'h04;
    localparam int          OPT_SRC_L = 0;
    localparam int          OPT_SRC_H = 2;
    localparam int          OPT_DBL   = 3;
    localparam int          OPT_DLY   = 4;
    localparam int          OPT_W     = 5;
    localparam logic [4:0]  OPT_RST   = 5'h10;
    localparam int          ST_PH_L   = 0;
    localparam int          ST_PH_H   = 1;
    localparam int          ST_EXT    = 2;
    localparam int          ST_LVD    = 3;
    localparam int          ST_WDG    = 4;
    localparam int          ST_DBL    = 5;
    localparam int          ST_PIN    = 6;
    // ************************************
    // clock source codes
    // ************************************
    localparam logic [2:0]  SRC_EXT   = 3'h0;
    localparam logic [2:0]  SRC_RES0  = 3'h1;
    localparam logic [2:0]  SRC_RC    = 3'h6;
    localparam int          RES_N     = 5;
    // ************************************
    // timing
    // ************************************
    localparam int          PCLK_NS   = 50;
    localparam int          PCLK_MHZ  = 20;
    localparam int          DBL_MIN_MHZ = 2;
    localparam int          DBL_MAX_MHZ = 4;
    localparam logic [7:0]  PER_MIN   = 8'(PCLK_MHZ / DBL_MAX_MHZ);
    localparam logic [7:0]  PER_MAX   = 8'(PCLK_MHZ / DBL_MIN_MHZ);
    localparam int          WDG_PULSE_NS = 500;
    localparam logic [4:0]  WDG_CYC   = 5'((WDG_PULSE_NS + PCLK_NS - 1) / PCLK_NS);
    localparam int          DLY_W     = 13;
    localparam int          DLY_SHORT = 256;
    localparam int          DLY_LONG  = 4096;
    localparam logic        FETCH_LAST = 1'b1;
    localparam logic [15:0] VEC_LO    = 16'hfffe;
    localparam logic [15:0] VEC_HI    = 16'hffff;
    // ************************************
    // sequence phases
    // ************************************
    typedef enum logic [1:0] {
        PH_ACTIVE = 2'b00,
        PH_DELAY  = 2'b01,
        PH_FETCH  = 2'b10,
        PH_RUN    = 2'b11
    } rsc_phase_t;
endpackage : rsc_pkg
`default_nettype wire

//--- shared/rsc_clk_if.sv
// carrier between the sequencer top and its clock path
// assumes both ends run on pclk
`timescale 1ns/1ns
`default_nettype none
interface rsc_clk_if;
    logic [2:0] src;
    logic       dbl_en;
    logic       dbl_act;
    logic       int_clk;
    modport ctl  (output src, output dbl_en, input dbl_act, input int_clk);
    modport path (input src, input dbl_en, output dbl_act, output int_clk);
endinterface : rsc_clk_if
`default_nettype wire

//--- hdl/rsc_clk_path.sv
// main clock path: source select, divide by two or double
// assumes oscillator levels arrive asynchronously to pclk
`timescale 1ns/1ns
`default_nettype none
module rsc_clk_path
    import rsc_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         osc_i,
    input  wire logic         rc_i,
    output logic [RES_N-1:0]  res_en,
    output logic              rc_en,
    rsc_clk_if.path           cif
);
    logic [1:0] s1_r, s2_r, s3_r;
    logic [1:0] lvl_r;
    logic       sel, sel_d_r, rise, edg, clk_r;
    logic [7:0] per_r, since_rise_r, since_edge_r;
    // ************************************
    // source enables
    // ************************************
    // resonators stay enabled through reset: no restart wait
    always_comb begin
        for (int k = 0; k < RES_N; k++) begin
            res_en[k] = (cif.src == SRC_RES0 + 3'(k)); // RULE3 RULE4
        end
        rc_en = (cif.src == SRC_RC); // RULE3
    end
    // three-stage sync, level moves once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r  <= 2'h0;
            s2_r  <= 2'h0;
            s3_r  <= 2'h0;
            lvl_r <= 2'h0;
        end else begin
            s1_r <= {rc_i, osc_i};
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int k = 0; k < 2; k++) begin
                if (s2_r[k] == s3_r[k]) lvl_r[k] <= s3_r[k];
            end
        end
    end
    assign sel  = rc_en ? lvl_r[1] : lvl_r[0]; // RULE3
    assign rise = sel & ~sel_d_r;
    assign edg  = sel ^ sel_d_r;
    // period measure; doubling only in the 2..4 MHz band
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_d_r      <= 1'b0;
            per_r        <= 8'h00;
            since_rise_r <= 8'h00;
            since_edge_r <= 8'h00;
        end else begin
            sel_d_r <= sel;
            if (rise) per_r <= since_rise_r + 8'h01;
            if (rise) since_rise_r <= 8'h00;
            else if (since_rise_r != 8'hff) since_rise_r <= since_rise_r + 8'h01;
            if (edg) since_edge_r <= 8'h00;
            else if (since_edge_r != 8'hff) since_edge_r <= since_edge_r + 8'h01;
        end
    end
    assign cif.dbl_act = cif.dbl_en && !rc_en && per_r >= PER_MIN && per_r <= PER_MAX; // RULE1
    // doubler: high after every edge for a quarter input period plus one pclk cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_r <= 1'b0;
        end else if (cif.dbl_act) begin
            if (edg) clk_r <= 1'b1; // RULE1
            else if (since_edge_r >= (per_r >> 2)) clk_r <= 1'b0;
        end else if (rise) begin
            clk_r <= ~clk_r; // RULE2
        end
    end
    assign cif.int_clk = clk_r;

    dbl_edge_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        cif.dbl_act && edg |=> clk_r) else $error("doubler missed an edge");
    div_two_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        !cif.dbl_act && !$past(cif.dbl_act) && $changed(clk_r) |-> $past(rise))
        else $error("divider moved without a rising input");
    one_src_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        $onehot0({res_en, rc_en})) else $error("more than one oscillator enabled");
endmodule : rsc_clk_path
`default_nettype wire

//--- hdl/rsc_seq_top.sv
// reset sequencer with option-selected clock path, apb slave
// assumes a bidirectional open-drain reset pin resolved outside
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RULE1: doubler gives twice a 2-4 MHz input; the rc source is still divided by two with the doubler on
// RULE2: doubler off gives oscillator divided by two
// RULE3: option picks external, five resonators, or rc
// RULE4: resonator keeps running while in reset
// RULE5: pin, detector, watchdog sources; pin low in delay
// RULE6: reset vector fetched from fffe then ffff
// RULE7: phases are active, stabilise delay, vector fetch
// RULE8: vector fetch lasts two clock cycles
// RULE9: reset pin is input plus open-drain output
// RULE10: low pin enters reset without a clock
// RULE11: option selects 256 or 4096 cycle delay
// RULE12: watchdog underflow drives pin low minimum time
// RULE13: delay starts after all sources clear, restarts
// RULE14: pin reset synchronised before internal release
module rsc_seq_top
    import rsc_pkg::*;
#(
    parameter int DLY_LONG_CYC = DLY_LONG
)(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             rst_pin_i,
    output logic                  rst_pin_o,
    output logic                  rst_pin_oe,
    input  wire logic             low_voltage_detector_i,
    input  wire logic             wdg_uflow_i,
    input  wire logic             oscillator_input_pin_i,
    input  wire logic             rc_osc_i,
    output logic [rsc_pkg::RES_N-1:0] res_osc_en,
    output logic                  rc_osc_en,
    output logic                  internal_clock,
    output logic                  core_rst_n,
    output logic                  vec_fetch,
    output logic [15:0]           vec_addr
);
    import rsc_pkg::*;

    rsc_phase_t         st_r, st_nxt;
    logic [OPT_W-1:0]   opt_r;
    logic [1:0]         s1_r, s2_r, s3_r;
    logic               pin_lvl_r, lvd_lvl_r;
    logic               mask_r, ext_hit_r, arst_n;
    logic [4:0]         wdg_r, wdg_nxt;
    logic               wdg_src, src_any, drive_nxt;
    logic [DLY_W-1:0]   dly_r, dly_last;
    logic               fcnt_r;
    logic               oe_r, crst_r, vf_r;
    logic [15:0]        va_r;
    logic [31:0]        rd_r;
    logic               hit_opt, hit_stat;
    rsc_clk_if          cif ();

    // ************************************
    // clock path
    // ************************************
    assign cif.src    = opt_r[OPT_SRC_H:OPT_SRC_L]; // RULE3
    assign cif.dbl_en = opt_r[OPT_DBL]; // RULE1

    rsc_clk_path u_clk (
        .pclk    (pclk),
        .presetn (presetn),
        .osc_i   (oscillator_input_pin_i),
        .rc_i    (rc_osc_i),
        .res_en  (res_osc_en),
        .rc_en   (rc_osc_en),
        .cif     (cif.path)
    );
    assign internal_clock = cif.int_clk;

    // ************************************
    // source capture
    // ************************************
    // pin and detector pass three flops; level moves once two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r      <= 2'h1; // idle levels: pin high, detector low
            s2_r      <= 2'h1;
            s3_r      <= 2'h1;
            pin_lvl_r <= 1'b0;
            lvd_lvl_r <= 1'b0;
        end else begin
            s1_r <= {low_voltage_detector_i, rst_pin_i}; // RULE14
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r[0] == s3_r[0]) pin_lvl_r <= s3_r[0]; // RULE14
            if (s2_r[1] == s3_r[1]) lvd_lvl_r <= s3_r[1]; // RULE5
        end
    end

    // own drive would read back as an outside reset, so the async
    // path stays masked while driving and until the pin is seen high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 1'b1;
        end else begin
            mask_r <= drive_nxt | (mask_r & ~pin_lvl_r); // RULE9
        end
    end
    assign arst_n = presetn & (rst_pin_i | mask_r); // RULE10

    // outside low level sets this without a clock; cleared on a
    // synchronised high so release is clean
    always_ff @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            ext_hit_r <= 1'b1; // RULE10
        end else if (pin_lvl_r && !mask_r) begin
            ext_hit_r <= 1'b0; // RULE14
        end
    end

    // watchdog pulse stretched to the minimum pin low time
    always_comb begin
        wdg_nxt = wdg_r;
        if (wdg_uflow_i) wdg_nxt = WDG_CYC; // RULE12
        else if (wdg_r != 5'h00) wdg_nxt = wdg_r - 5'h01;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdg_r <= 5'h00;
        end else begin
            wdg_r <= wdg_nxt;
        end
    end
    assign wdg_src = (wdg_r != 5'h00);
    assign src_any = ext_hit_r | lvd_lvl_r | wdg_src; // RULE5

    // ************************************
    // sequence state machine
    // ************************************
    assign dly_last = opt_r[OPT_DLY] ? DLY_W'(DLY_LONG_CYC - 1)
                                     : DLY_W'(DLY_SHORT - 1); // RULE11

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            PH_ACTIVE: begin
                if (!src_any) st_nxt = PH_DELAY; // RULE13
            end
            PH_DELAY: begin
                if (src_any) st_nxt = PH_ACTIVE; // RULE13
                else if (dly_r == dly_last) st_nxt = PH_FETCH; // RULE7
            end
            PH_FETCH: begin
                if (src_any) st_nxt = PH_ACTIVE;
                else if (fcnt_r == FETCH_LAST) st_nxt = PH_RUN; // RULE8
            end
            PH_RUN: begin
                if (src_any) st_nxt = PH_ACTIVE; // RULE7
            end
            default: st_nxt = PH_ACTIVE;
        endcase
    end

    always_ff @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= PH_ACTIVE; // RULE10
        end else begin
            st_r <= st_nxt;
        end
    end

    // delay count, cleared whenever a source reasserts
    always_ff @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            dly_r <= '0;
        end else if (st_r == PH_DELAY && st_nxt == PH_DELAY) begin
            dly_r <= dly_r + DLY_W'(1); // RULE7
        end else begin
            dly_r <= '0; // RULE13
        end
    end

    always_ff @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            fcnt_r <= 1'b0;
        end else begin
            fcnt_r <= (st_r == PH_FETCH && st_nxt == PH_FETCH); // RULE8
        end
    end

    // ************************************
    // pin drive and core outputs
    // ************************************
    // internal sources and the delay phase pull the pin low; wdg_src covers
    // the edge between the stretched pulse and the delay, so no gap shows
    assign drive_nxt = (st_nxt == PH_DELAY) | lvd_lvl_r | (wdg_nxt != 5'h00) | wdg_src;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_r <= 1'b1;
        end else begin
            oe_r <= drive_nxt; // RULE5 RULE12
        end
    end
    assign rst_pin_oe = oe_r; // RULE9
    assign rst_pin_o  = 1'b0;

    // core release only from the synchronous state register
    always_ff @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            crst_r <= 1'b0;
            vf_r   <= 1'b0;
            va_r   <= VEC_LO;
        end else begin
            crst_r <= (st_nxt == PH_RUN); // RULE14
            vf_r   <= (st_nxt == PH_FETCH); // RULE8
            va_r   <= (st_nxt == PH_FETCH && st_r == PH_FETCH) ? VEC_HI : VEC_LO; // RULE6
        end
    end
    assign core_rst_n = crst_r;
    assign vec_fetch  = vf_r;
    assign vec_addr   = va_r;

    // ************************************
    // apb slave
    // ************************************
    assign hit_opt  = (paddr == OFF_OPT);
    assign hit_stat = (paddr == OFF_STAT);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~(hit_opt | hit_stat);

    // option register; survives pin resets, only presetn clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_r <= OPT_RST;
        end else if (psel && penable && pwrite && hit_opt) begin
            opt_r <= pwdata[OPT_W-1:0]; // RULE3 RULE11
        end
    end

    // read data captured in the setup cycle, so no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            rd_r <= 32'h0000_0000;
            if (hit_opt) rd_r[OPT_W-1:0] <= opt_r;
            if (hit_stat) begin
                rd_r[ST_PH_H:ST_PH_L] <= st_r;
                rd_r[ST_EXT] <= ext_hit_r;
                rd_r[ST_LVD] <= lvd_lvl_r;
                rd_r[ST_WDG] <= wdg_src;
                rd_r[ST_DBL] <= cif.dbl_act;
                rd_r[ST_PIN] <= pin_lvl_r;
            end
        end
    end
    assign prdata = rd_r;

    // ************************************
    // checks
    // ************************************
    delay_to_fetch_a: assert property (@(posedge pclk) disable iff (!arst_n) // RULE7
        st_r == PH_DELAY && dly_r == dly_last && !src_any |=> st_r == PH_FETCH)
        else $error("delay end did not enter fetch");
    fetch_two_a: assert property (@(posedge pclk) disable iff (!arst_n) // RULE8
        $rose(vec_fetch) && !src_any ##1 !src_any |-> vec_fetch ##1 !vec_fetch)
        else $error("fetch not two cycles");
    vector_addr_a: assert property (@(posedge pclk) disable iff (!arst_n) // RULE6
        $rose(vec_fetch) |-> vec_addr == 16'hfffe ##1 (!vec_fetch || vec_addr == 16'hffff))
        else $error("wrong reset vector address");
    pin_in_delay_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        st_r == PH_DELAY |-> rst_pin_oe && !rst_pin_o)
        else $error("pin released during delay");
    delay_restart_a: assert property (@(posedge pclk) disable iff (!arst_n) // RULE13
        st_r == PH_DELAY && src_any |=> st_r == PH_ACTIVE && dly_r == '0)
        else $error("delay not restarted");
    wdg_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        wdg_uflow_i |=> rst_pin_oe [*8])
        else $error("watchdog pin pulse too short");
    core_hold_a: assert property (@(posedge pclk) disable iff (!arst_n) // RULE14
        $rose(core_rst_n) |-> $past(vec_fetch) && st_r == PH_RUN)
        else $error("core released outside run");
    short_delay_a: assert property (@(posedge pclk) disable iff (!arst_n) // RULE11
        st_r == PH_FETCH && $past(st_r) == PH_DELAY && !opt_r[OPT_DLY]
        |-> $past(dly_r) == 13'd255)
        else $error("short delay length wrong");
endmodule : rsc_seq_top
`default_nettype wire

//--- verif/rsc_ext_rst.sv
// far-side model: external reset circuit on the open-drain reset pin
// assumes the device pulls the pin only low, and only while its enable is high
`timescale 1ns/1ns
`default_nettype none
module rsc_ext_rst #(
    parameter int HOLD_CYC = 8
)(
    input  wire logic pclk,
    input  wire logic pull_req,
    input  wire logic dev_o,
    input  wire logic dev_oe,
    output logic      pin
);
    logic [7:0] hold_r = 8'h00;

    // stretch a request so the low pulse is long enough to be recognised
    always @(posedge pclk) begin
        if (pull_req) begin
            hold_r <= 8'(HOLD_CYC);
        end else if (hold_r != 8'h00) begin
            hold_r <= hold_r - 8'h01;
        end
    end

    // wired-and of both open-drain drivers; the weak pull-up wins when idle
    assign pin = (pull_req || hold_r != 8'h00 || (dev_oe && !dev_o)) ? 1'b0 : 1'b1;
endmodule : rsc_ext_rst
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the reset sequencer and main clock path
// assumes the package, interface and design files are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import rsc_pkg::*;
    // ************************************
    // signals
    // ************************************
    localparam int N = 64;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic             e, pull_req, pin, rst_pin_o, rst_pin_oe, lvd_req, wdg_uflow, osc;
    logic             rc_osc_en, internal_clock, core_rst_n, vec_fetch;
    logic [RES_N-1:0] res_osc_en;
    logic [15:0]      vec_addr;
    logic [2:0]       osc_div;
    int               error_cnt, tests_run;

    rsc_seq_top #(.DLY_LONG_CYC(N)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rst_pin_i(pin), .rst_pin_o(rst_pin_o),
        .rst_pin_oe(rst_pin_oe), .low_voltage_detector_i(lvd_req),
        .wdg_uflow_i(wdg_uflow), .oscillator_input_pin_i(osc), .rc_osc_i(osc),
        .res_osc_en(res_osc_en), .rc_osc_en(rc_osc_en), .internal_clock(internal_clock),
        .core_rst_n(core_rst_n), .vec_fetch(vec_fetch), .vec_addr(vec_addr)
    );

    rsc_ext_rst u_ext (
        .pclk(pclk), .pull_req(pull_req), .dev_o(rst_pin_o), .dev_oe(rst_pin_oe), .pin(pin)
    );

    // oscillator at pclk/8 (2.5 MHz), inside the doubler's input window
    assign osc = osc_div[2];
    always @(posedge pclk) begin
        osc_div <= osc_div + 3'h1;
    end

    // ************************************
    // shared tasks
    // ************************************
    task automatic report_and_stop();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            error_cnt++;
            report_and_stop();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // waits for the vector fetch, judging delay length and the fetch itself
    task automatic seq_wait(input int dly, input int lo, input int hi);
        int n;
        int run;
        logic bad;
        n = 0;
        run = 0;
        bad = 1'b0;
        while (vec_fetch !== 1'b1 && n < 6000) begin
            @(negedge pclk);
            n++;
            // the pin is released with the fetch, so keep the count then
            if (pin === 1'b0) run++;
            else if (vec_fetch !== 1'b1) run = 0;
            if (vec_fetch !== 1'b1 && core_rst_n !== 1'b0) bad = 1'b1;
        end
        if (n >= 6000) begin
            error_cnt++;
            report_and_stop();
        end
        chk(n >= lo && n <= hi, 1'b1);
        chk(run >= dly, 1'b1);
        chk(bad, 1'b0);
        chk(vec_addr, 16'hfffe);
        @(negedge pclk);
        chk({vec_fetch, vec_addr}, {1'b1, 16'hffff});
        @(negedge pclk);
        chk({vec_fetch, core_rst_n, rst_pin_oe}, 3'b010);
    endtask : seq_wait

    // counts internal clock rises over 80 cycles once the path has settled
    task automatic count_rise(input logic [4:0] opt, output int c);
        logic p;
        apb(1'b1, OFF_OPT, 32'(opt));
        repeat (40) @(negedge pclk);
        c = 0;
        p = internal_clock;
        repeat (80) begin
            @(negedge pclk);
            if (internal_clock === 1'b1 && p === 1'b0) c++;
            p = internal_clock;
        end
    endtask : count_rise

    // ************************************
    // scenarios
    // ************************************
    task automatic t_boot();
        seq_wait(N, N + 1, N + 10);
        apb(1'b0, OFF_OPT, 32'h0);
        chk(rd, 32'h10);
        apb(1'b1, OFF_STAT, 32'h0);
        chk(e, 1'b0);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd[ST_PIN:ST_PH_L], 7'h43);
        apb(1'b1, 8'h08, 32'hffff_ffff);
        chk(e, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        chk({e, rd[30:0]}, {1'b1, 31'h0});
    endtask : t_boot

    // watchdog pulse from run; resonator range 3 must keep running
    task automatic t_wdg(input logic [4:0] opt, input int dly);
        apb(1'b1, OFF_OPT, 32'(opt));
        @(posedge pclk);
        wdg_uflow <= 1'b1;
        @(posedge pclk);
        wdg_uflow <= 1'b0;
        // the pulse is stretched first, so the phase leaves run one edge later
        repeat (2) @(negedge pclk);
        chk({core_rst_n, rst_pin_oe, pin}, 3'b010);
        chk(res_osc_en, 5'h04);
        seq_wait(dly, dly + 6, dly + 14);
    endtask : t_wdg

    // detector held, then a watchdog pulse mid-delay must restart the count
    task automatic t_lvd();
        @(posedge pclk);
        lvd_req <= 1'b1;
        repeat (20) @(negedge pclk);
        chk({core_rst_n, rst_pin_oe, pin}, 3'b010);
        @(posedge pclk);
        lvd_req <= 1'b0;
        repeat (20) @(posedge pclk);
        wdg_uflow <= 1'b1;
        @(posedge pclk);
        wdg_uflow <= 1'b0;
        seq_wait(N, N + 6, N + 14);
    endtask : t_lvd

    // external pull seen without waiting for an edge
    task automatic t_ext();
        // detection re-arms only once the released pin is seen high again
        repeat (8) @(posedge pclk);
        pull_req <= 1'b1;
        #5;
        chk(core_rst_n, 1'b0);
        @(posedge pclk);
        pull_req <= 1'b0;
        seq_wait(N, N + 8, N + 22);
    endtask : t_ext

    task automatic t_clk();
        int c;
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, OFF_OPT, 32'h10 | k);
            @(negedge pclk);
            chk(res_osc_en, (k >= 1 && k <= 5) ? 5'(1 << (k - 1)) : 5'h0);
            chk(rc_osc_en, k == 6);
        end
        count_rise(5'h10, c);
        chk(c >= 4 && c <= 6, 1'b1);
        count_rise(5'h18, c);
        chk(c >= 18 && c <= 22, 1'b1);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd[ST_DBL], 1'b1);
        count_rise(5'h1e, c);
        chk(c >= 4 && c <= 6, 1'b1);
    endtask : t_clk

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // main sequence: reset held for ten cycles, then every scenario in turn
    initial begin
        error_cnt = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pull_req = 1'b0;
        lvd_req = 1'b0;
        wdg_uflow = 1'b0;
        osc_div = 3'h0;
        repeat (9) @(posedge pclk);
        @(negedge pclk);
        chk({core_rst_n, vec_fetch, rst_pin_oe}, 3'b001);
        @(posedge pclk);
        presetn <= 1'b1;
        t_boot();
        t_wdg(5'h13, N);
        t_lvd();
        t_ext();
        // short delay last of the reset scenarios: the ones above expect the long one
        t_wdg(5'h03, 256);
        t_clk();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
